// [capture_pkg.sv]
// Overview of operation
// - two independent capture channels, each with its own pin and held position.
// - one-time mode latches position on first qualifying edge after arming, ignores later edges.
// - continuous mode latches on every qualifying edge, overwriting the held value.
// - edge select: 0 falling, 1 rising, 2 both; reset value 0.
// - edge select, start/stop and real-time control writes act at once.
// - real-time word bit 0 arms one-time capture on input 1, bit 1 on input 2.
// - start/stop codes: 0 cancel, 1 one-time, 2 continuous; 3 and 4 reserved.
// - one-time capture disarms after first latch; continuous stays armed until cancelled.
// - real-time word arms only one-time capture; clearing its bit cancels either mode, and its status flags report both modes.
// - captured flag per channel: bit 0 for input 1, bit 1 for input 2.
// - captured position is signed 32 bit, shifted when position reference is re-homed.
package capture_pkg;

  // ---------------------------------------------------------------
  // widths and types
  // ---------------------------------------------------------------
  localparam int NUM_CH     = 2;
  localparam int POS_MSB    = 31;
  localparam int POS_LO_MSB = 15;
  localparam int POS_HI_LSB = 16;

  typedef logic [3:0]         idx_t;
  typedef logic [15:0]        word_t;
  typedef logic signed [31:0] pos_t;

  // ---------------------------------------------------------------
  // parameter indices
  // ---------------------------------------------------------------
  localparam idx_t IDX_EDGE_ONE    = 4'h0;
  localparam idx_t IDX_EDGE_TWO    = 4'h1;
  localparam idx_t IDX_RT_CTRL     = 4'h2;
  localparam idx_t IDX_SS_ONE      = 4'h3;
  localparam idx_t IDX_SS_TWO      = 4'h4;
  localparam idx_t IDX_RT_STATUS   = 4'h5;
  localparam idx_t IDX_POS_ONE_LO  = 4'h6;
  localparam idx_t IDX_POS_ONE_HI  = 4'h7;
  localparam idx_t IDX_POS_TWO_LO  = 4'h8;
  localparam idx_t IDX_POS_TWO_HI  = 4'h9;

  // ---------------------------------------------------------------
  // field codes and reset values
  // ---------------------------------------------------------------
  localparam word_t EDGE_FALLING = 16'h0000;
  localparam word_t EDGE_RISING  = 16'h0001;
  localparam word_t EDGE_BOTH    = 16'h0002;
  localparam word_t SS_STOP      = 16'h0000;
  localparam word_t SS_ONCE      = 16'h0001;
  localparam word_t SS_CONT      = 16'h0002;
  localparam word_t WORD_RESET   = 16'h0000;
  localparam pos_t  POS_RESET    = 32'h0000_0000;

  // mode codes match the start/stop read-back codes
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_ONCE = 2'b01,
    MODE_CONT = 2'b10
  } mode_e;

  // qualifying edge decode; unknown codes qualify nothing
  function automatic logic edge_hit(input word_t sel, input logic rise, input logic fall);
    case (sel)
      EDGE_FALLING: edge_hit = fall;
      EDGE_RISING:  edge_hit = rise;
      EDGE_BOTH:    edge_hit = rise | fall;
      default:      edge_hit = 1'b0;
    endcase
  endfunction

endpackage

// [cap_chan_if.sv]
`timescale 1ns/100ps
interface cap_chan_if;
  import capture_pkg::*;
  word_t edge_sel;
  logic  arm_once;
  logic  arm_cont;
  logic  cancel;
  logic  rebase;
  pos_t  delta;
  mode_e mode;
  logic  captured;
  pos_t  position;
  logic  hit;

  modport ctrl (output edge_sel, arm_once, arm_cont, cancel, rebase, delta,
                input  mode, captured, position, hit);
  modport chan (input  edge_sel, arm_once, arm_cont, cancel, rebase, delta,
                output mode, captured, position, hit);
endinterface

// [capture_channel.sv]
`timescale 1ns/100ps
module capture_channel (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              pin_in,
  input  wire capture_pkg::pos_t motor_pos_in,
  cap_chan_if.chan               bus
);
  import capture_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic  sync1;
    logic  sync2;
    logic  prev;
    mode_e mode;
    logic  captured;
    pos_t  position;
    logic  hit;
  } chan_s;

  chan_s state_r;
  chan_s state_nxt;
  logic  rise;
  logic  fall;
  logic  qual;
  logic  armed;
  logic  rearm;

  assign rise  = state_r.sync2 & ~state_r.prev;
  assign fall  = ~state_r.sync2 & state_r.prev;
  assign qual  = edge_hit(bus.edge_sel, rise, fall);
  assign armed = (state_r.mode != MODE_IDLE);
  assign rearm = bus.arm_once | bus.arm_cont;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt       = state_r;
    state_nxt.sync1 = pin_in;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.prev  = state_r.sync2;
    state_nxt.hit   = 1'b0;
    if (bus.rebase) begin
      state_nxt.position = pos_t'(state_r.position + bus.delta);
    end
    if (bus.cancel) begin
      state_nxt.mode = MODE_IDLE;
    end
    if (bus.arm_once) begin
      state_nxt.mode     = MODE_ONCE;
      state_nxt.captured = 1'b0;
    end
    if (bus.arm_cont) begin
      state_nxt.mode     = MODE_CONT;
      state_nxt.captured = 1'b0;
    end
    // capture after commands so an edge on an already armed channel is kept when a command lands in the same cycle
    if (qual && armed) begin
      state_nxt.position = motor_pos_in;
      state_nxt.captured = 1'b1;
      state_nxt.hit      = 1'b1;
      if (state_r.mode == MODE_ONCE && !rearm) begin
        state_nxt.mode = MODE_IDLE;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= '{sync1: 1'b0, sync2: 1'b0, prev: 1'b0, mode: MODE_IDLE,
                   captured: 1'b0, position: POS_RESET, hit: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bus.mode     = state_r.mode;
  assign bus.captured = state_r.captured;
  assign bus.position = state_r.position;
  assign bus.hit      = state_r.hit;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_latch_sampled: assert property (state_r.hit |-> state_r.position == $past(motor_pos_in))
    else $error("captured position does not match edge cycle");
  a_once_disarms: assert property ((state_r.mode == MODE_ONCE && qual && !rearm) |=>
    (state_r.mode == MODE_IDLE && state_r.hit && state_r.captured))
    else $error("one-time capture did not disarm");
  a_cont_keeps: assert property ((state_r.mode == MODE_CONT && qual && !bus.cancel && !bus.arm_once) |=>
    (state_r.mode == MODE_CONT && state_r.hit))
    else $error("continuous capture stopped");
  a_idle_ignores: assert property ((!armed && !bus.rebase) |=> $stable(state_r.position) && !state_r.hit)
    else $error("disarmed channel captured");
  a_rising_only: assert property ((bus.edge_sel == EDGE_RISING && fall) |=> !state_r.hit)
    else $error("falling edge taken in rising mode");
  a_rebase_shift: assert property ((bus.rebase && !(qual && armed)) |=>
    state_r.position == pos_t'($past(state_r.position) + $past(bus.delta)))
    else $error("position not shifted on re-home");

  c_once_capture: cover property (state_r.mode == MODE_ONCE ##1 state_r.hit);
  c_cont_twice:   cover property (state_r.hit && state_r.mode == MODE_CONT ##[1:50] state_r.hit);
  c_rebase:       cover property (bus.rebase && state_r.captured);

endmodule

// [dual_position_capture.sv]
`timescale 1ns/100ps
module dual_position_capture (
  input  wire logic                 CLOCK_IN,
  input  wire logic                 RST_IN,
  input  wire logic                 TOUCH_PROBE_ONE_IN,
  input  wire logic                 TOUCH_PROBE_TWO_IN,
  input  wire capture_pkg::pos_t    MOTOR_POS_IN,
  input  wire logic                 REF_SET_IN,
  input  wire capture_pkg::pos_t    REF_DELTA_IN,
  input  wire logic                 PARAM_WR_IN,
  input  wire logic                 PARAM_RD_IN,
  input  wire capture_pkg::idx_t    PARAM_IDX_IN,
  input  wire capture_pkg::word_t   PARAM_WDATA_IN,
  output logic                      PARAM_RVALID_OUT,
  output capture_pkg::word_t        PARAM_RDATA_OUT,
  output logic [1:0]                REALTIME_STATUS_OUT,
  output capture_pkg::pos_t         CAPTURE1_POSITION_OUT,
  output capture_pkg::pos_t         CAPTURE2_POSITION_OUT
);
  import capture_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    word_t [NUM_CH-1:0] edge_sel;
    logic  [NUM_CH-1:0] rt_ctrl;
    word_t              rdata;
    logic               rvalid;
    word_t              snap_hi;
  } top_s;

  top_s               state_r;
  top_s               state_nxt;
  logic [NUM_CH-1:0]  pins;
  logic [NUM_CH-1:0]  captured_w;
  logic [NUM_CH-1:0]  hit_w;
  mode_e              mode_w [NUM_CH];
  pos_t               pos_w  [NUM_CH];
  logic [NUM_CH-1:0]  rt_rise;
  logic [NUM_CH-1:0]  rt_fall;
  logic [NUM_CH-1:0]  ss_once;
  logic [NUM_CH-1:0]  ss_cont;
  logic [NUM_CH-1:0]  ss_stop;
  logic               rt_wr;

  assign pins  = {TOUCH_PROBE_TWO_IN, TOUCH_PROBE_ONE_IN};
  assign rt_wr = PARAM_WR_IN && (PARAM_IDX_IN == IDX_RT_CTRL);

  cap_chan_if ch_if [NUM_CH] ();

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  // commands are decoded straight from the write so they act in the write's own cycle
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam idx_t SS_IDX = (i == 0) ? IDX_SS_ONE : IDX_SS_TWO;
    logic ss_wr;

    assign ss_wr      = PARAM_WR_IN && (PARAM_IDX_IN == SS_IDX);
    assign ss_stop[i] = ss_wr && (PARAM_WDATA_IN == SS_STOP);
    assign ss_once[i] = ss_wr && (PARAM_WDATA_IN == SS_ONCE);
    assign ss_cont[i] = ss_wr && (PARAM_WDATA_IN == SS_CONT);
    // only a change of a control bit acts, so rewriting one channel's bit leaves the other alone
    assign rt_rise[i] = rt_wr && PARAM_WDATA_IN[i] && !state_r.rt_ctrl[i];
    assign rt_fall[i] = rt_wr && !PARAM_WDATA_IN[i] && state_r.rt_ctrl[i];

    assign ch_if[i].edge_sel = state_r.edge_sel[i];
    assign ch_if[i].arm_once = ss_once[i] | rt_rise[i];
    assign ch_if[i].arm_cont = ss_cont[i];
    assign ch_if[i].cancel   = ss_stop[i] | rt_fall[i];
    assign ch_if[i].rebase   = REF_SET_IN;
    assign ch_if[i].delta    = REF_DELTA_IN;

    assign captured_w[i] = ch_if[i].captured;
    assign hit_w[i]      = ch_if[i].hit;
    assign mode_w[i]     = ch_if[i].mode;
    assign pos_w[i]      = ch_if[i].position;

    capture_channel capture_channel_inst (
      .clk_in       (CLOCK_IN),
      .rst_in       (RST_IN),
      .pin_in       (pins[i]),
      .motor_pos_in (MOTOR_POS_IN),
      .bus          (ch_if[i])
    );
  end

  // ---------------------------------------------------------------
  // parameter access
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt        = state_r;
    state_nxt.rvalid = PARAM_RD_IN;
    if (PARAM_WR_IN) begin
      case (PARAM_IDX_IN)
        IDX_EDGE_ONE:  state_nxt.edge_sel[0] = PARAM_WDATA_IN;
        IDX_EDGE_TWO:  state_nxt.edge_sel[1] = PARAM_WDATA_IN;
        IDX_RT_CTRL:   state_nxt.rt_ctrl = PARAM_WDATA_IN[NUM_CH-1:0];
        default:       state_nxt.rt_ctrl = state_r.rt_ctrl;
      endcase
    end
    // the high half is frozen when the low half is read, so a 32-bit read never tears
    if (PARAM_RD_IN) begin
      case (PARAM_IDX_IN)
        IDX_EDGE_ONE:    state_nxt.rdata = state_r.edge_sel[0];
        IDX_EDGE_TWO:    state_nxt.rdata = state_r.edge_sel[1];
        IDX_RT_CTRL:     state_nxt.rdata = word_t'(state_r.rt_ctrl);
        IDX_SS_ONE:      state_nxt.rdata = word_t'(mode_w[0]);
        IDX_SS_TWO:      state_nxt.rdata = word_t'(mode_w[1]);
        IDX_RT_STATUS:   state_nxt.rdata = word_t'(captured_w);
        IDX_POS_ONE_LO:  begin
          state_nxt.rdata   = pos_w[0][POS_LO_MSB:0];
          state_nxt.snap_hi = pos_w[0][POS_MSB:POS_HI_LSB];
        end
        IDX_POS_TWO_LO:  begin
          state_nxt.rdata   = pos_w[1][POS_LO_MSB:0];
          state_nxt.snap_hi = pos_w[1][POS_MSB:POS_HI_LSB];
        end
        IDX_POS_ONE_HI:  state_nxt.rdata = state_r.snap_hi;
        IDX_POS_TWO_HI:  state_nxt.rdata = state_r.snap_hi;
        default:         state_nxt.rdata = WORD_RESET;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r <= '{edge_sel: {EDGE_FALLING, EDGE_FALLING}, rt_ctrl: '0,
                   rdata: WORD_RESET, rvalid: 1'b0, snap_hi: WORD_RESET};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign PARAM_RVALID_OUT      = state_r.rvalid;
  assign PARAM_RDATA_OUT       = state_r.rdata;
  assign REALTIME_STATUS_OUT   = captured_w;
  assign CAPTURE1_POSITION_OUT = pos_w[0];
  assign CAPTURE2_POSITION_OUT = pos_w[1];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  a_edge_write: assert property ((PARAM_WR_IN && PARAM_IDX_IN == IDX_EDGE_ONE) |=>
    state_r.edge_sel[0] == $past(PARAM_WDATA_IN))
    else $error("edge select write not applied");
  a_rt_arm: assert property ((rt_wr && PARAM_WDATA_IN[0] && !state_r.rt_ctrl[0]) |=>
    (mode_w[0] == MODE_ONCE || hit_w[0]))
    else $error("real-time bit did not arm one-time capture");
  a_rt_cancel: assert property ((rt_wr && !PARAM_WDATA_IN[1] && state_r.rt_ctrl[1]) |=>
    mode_w[1] == MODE_IDLE)
    else $error("real-time clear did not cancel capture");
  a_ss_cont: assert property ((PARAM_WR_IN && PARAM_IDX_IN == IDX_SS_TWO && PARAM_WDATA_IN == SS_CONT) |=>
    mode_w[1] == MODE_CONT)
    else $error("start/stop code 2 did not start continuous capture");
  a_flag_cause: assert property ($rose(REALTIME_STATUS_OUT[0]) |-> $past(mode_w[0]) != MODE_IDLE)
    else $error("captured flag set without an armed channel");
  a_chan_apart: assert property ((PARAM_WR_IN && PARAM_IDX_IN == IDX_SS_ONE && !REF_SET_IN) ##1 !hit_w[1]
    |-> pos_w[1] == $past(pos_w[1]))
    else $error("channel 1 command disturbed channel 2");
  a_edge_two: assert property ((PARAM_WR_IN && PARAM_IDX_IN == IDX_EDGE_TWO) |=>
    state_r.edge_sel[1] == $past(PARAM_WDATA_IN))
    else $error("channel 2 edge select write not applied");
  a_reserved_code: assert property ((PARAM_WR_IN && PARAM_IDX_IN == IDX_SS_ONE && PARAM_WDATA_IN > SS_CONT) |=>
    (mode_w[0] == $past(mode_w[0]) || (hit_w[0] && mode_w[0] == MODE_IDLE)))
    else $error("reserved start/stop code changed the mode");
  a_rt_no_cont: assert property ((rt_wr && mode_w[0] != MODE_CONT) |=> mode_w[0] != MODE_CONT)
    else $error("real-time word started continuous capture");
  a_status_read: assert property ((PARAM_RD_IN && PARAM_IDX_IN == IDX_RT_STATUS) |=>
    PARAM_RDATA_OUT == word_t'($past(REALTIME_STATUS_OUT)))
    else $error("status read does not match captured flags");

  c_rt_once: cover property (rt_rise[0] ##[1:50] REALTIME_STATUS_OUT[0]);
  c_both_hit: cover property (hit_w[0] && hit_w[1]);

endmodule

// [trigger_model.sv]
`timescale 1ns/100ps
// ---------------------------------------------------------------
// external trigger source for the two capture pins
// ---------------------------------------------------------------
module trigger_model (
  input  wire logic       clk_in,
  output logic      [1:0] pin_out
);
  initial pin_out = 2'b00;

  // each level is held four cycles: shorter pulses may slip past the two-stage synchroniser
  task automatic drive(input int ch, input logic lvl);
    @(negedge clk_in);
    pin_out[ch] = lvl;
    repeat (4) @(negedge clk_in);
  endtask
endmodule

// [tb_dual_position_capture.sv]
`timescale 1ns/100ps
`define CHK(g, e, m) begin total_checks++; \
  if ((g) !== (e)) begin err_count++; $display("mismatch at %0t: %s", $time, m); end end
module tb_dual_position_capture;
  import capture_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  pos_t       motor = 32'h0000_0000;
  logic       ref_set = 1'b0;
  pos_t       ref_delta = 32'h0000_0000;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  idx_t       idx = 4'h0;
  word_t      wdata = 16'h0000;
  logic       rvalid;
  word_t      rdata;
  logic [1:0] status;
  pos_t       capture_input_one;
  pos_t       capture_input_two;
  logic [1:0] pins;
  int         err_count = 0;
  int         total_checks = 0;

  always #2.5 clk = ~clk;

  trigger_model trigger_model_inst (.clk_in(clk), .pin_out(pins));

  dual_position_capture dual_position_capture_inst (
    .CLOCK_IN(clk), .RST_IN(rst), .TOUCH_PROBE_ONE_IN(pins[0]), .TOUCH_PROBE_TWO_IN(pins[1]),
    .MOTOR_POS_IN(motor), .REF_SET_IN(ref_set), .REF_DELTA_IN(ref_delta), .PARAM_WR_IN(wr_en),
    .PARAM_RD_IN(rd_en), .PARAM_IDX_IN(idx), .PARAM_WDATA_IN(wdata), .PARAM_RVALID_OUT(rvalid),
    .PARAM_RDATA_OUT(rdata), .REALTIME_STATUS_OUT(status), .CAPTURE1_POSITION_OUT(capture_input_one),
    .CAPTURE2_POSITION_OUT(capture_input_two)
  );

  // ---------------------------------------------------------------
  // parameter access tasks
  // ---------------------------------------------------------------
  task automatic wr(input idx_t i, input word_t d);
    @(negedge clk);
    idx = i;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input idx_t i, output word_t d);
    @(negedge clk);
    idx = i;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    `CHK(rvalid, 1'b1, "read valid missing")
    d = rdata;
  endtask

  task automatic rdchk(input idx_t i, input word_t e);
    word_t d;
    rd(i, d);
    `CHK(d, e, "parameter read back")
  endtask

  // low word first: it freezes the high half for the second read
  task automatic pos_chk(input int ch, input pos_t e);
    word_t lo;
    word_t hi;
    rd(ch ? IDX_POS_TWO_LO : IDX_POS_ONE_LO, lo);
    rd(ch ? IDX_POS_TWO_HI : IDX_POS_ONE_HI, hi);
    `CHK({hi, lo}, e, "position by parameter")
    `CHK(ch ? capture_input_two : capture_input_one, e, "position output")
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #20000;
    err_count++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) rdchk(idx_t'(i), WORD_RESET);
    `CHK(status, 2'b00, "status after reset")
    $display("test reset done");

    wr(IDX_EDGE_ONE, EDGE_RISING);
    wr(IDX_SS_ONE, SS_ONCE);
    motor = 32'h0000_0064;
    trigger_model_inst.drive(0, 1'b1);
    pos_chk(0, 32'h0000_0064);
    `CHK(status, 2'b01, "flag one")
    rdchk(IDX_SS_ONE, SS_STOP);
    motor = 32'h0000_00c8;
    trigger_model_inst.drive(0, 1'b0);
    trigger_model_inst.drive(0, 1'b1);
    pos_chk(0, 32'h0000_0064);
    $display("test one-time done");

    wr(IDX_EDGE_TWO, EDGE_BOTH);
    wr(IDX_SS_TWO, SS_CONT);
    motor = 32'h0000_012c;
    trigger_model_inst.drive(1, 1'b1);
    pos_chk(1, 32'h0000_012c);
    motor = 32'hffff_fffb;
    trigger_model_inst.drive(1, 1'b0);
    pos_chk(1, 32'hffff_fffb);
    `CHK(capture_input_one, 32'h0000_0064, "channel one disturbed")
    `CHK(status, 2'b11, "flags both")
    rdchk(IDX_SS_TWO, SS_CONT);
    wr(IDX_SS_TWO, SS_STOP);
    motor = 32'h0000_01f4;
    trigger_model_inst.drive(1, 1'b1);
    pos_chk(1, 32'hffff_fffb);
    $display("test continuous done");

    wr(IDX_EDGE_ONE, EDGE_FALLING);
    wr(IDX_SS_ONE, SS_ONCE);
    `CHK(status, 2'b10, "arm clears flag")
    wr(IDX_SS_ONE, 16'h0003);
    wr(IDX_SS_ONE, 16'h0004);
    rdchk(IDX_SS_ONE, SS_ONCE);
    motor = 32'h0000_0258;
    trigger_model_inst.drive(0, 1'b0);
    pos_chk(0, 32'h0000_0258);
    wr(IDX_SS_ONE, SS_ONCE);
    motor = 32'h0000_02bc;
    trigger_model_inst.drive(0, 1'b1);
    pos_chk(0, 32'h0000_0258);
    trigger_model_inst.drive(0, 1'b0);
    pos_chk(0, 32'h0000_02bc);
    $display("test edge select done");

    wr(IDX_RT_CTRL, 16'h0000);
    wr(IDX_RT_CTRL, 16'h0001);
    rdchk(IDX_SS_ONE, SS_ONCE);
    motor = 32'h0000_0320;
    trigger_model_inst.drive(0, 1'b1);
    trigger_model_inst.drive(0, 1'b0);
    pos_chk(0, 32'h0000_0320);
    wr(IDX_RT_CTRL, 16'h0002);
    rdchk(IDX_SS_TWO, SS_ONCE);
    wr(IDX_RT_CTRL, 16'h0000);
    rdchk(IDX_SS_TWO, SS_STOP);
    motor = 32'h0000_0384;
    trigger_model_inst.drive(1, 1'b0);
    pos_chk(1, 32'hffff_fffb);
    rdchk(IDX_RT_STATUS, 16'h0001);
    $display("test real-time done");

    ref_delta = 32'h0001_0000;
    @(negedge clk);
    ref_set = 1'b1;
    @(negedge clk);
    ref_set = 1'b0;
    pos_chk(0, 32'h0001_0320);
    pos_chk(1, 32'h0000_fffb);
    $display("test re-home done");
    print_verdict();
  end
endmodule
